// *** sbqr_tx.sv ***
// Shared constants of the boot query responder and its serial byte transmitter.
package sbqr_pkg;
    localparam logic [7:0] SBQR_MATCH1_A = 8'h86;
    localparam logic [7:0] SBQR_MATCH1_B = 8'h30;
    localparam logic [7:0] SBQR_MATCH2_A = 8'h79;
    localparam logic [7:0] SBQR_MATCH2_B = 8'hCF;
    localparam logic [7:0] SBQR_CMD_SUM = 8'h90;
    localparam logic [7:0] SBQR_CMD_ID = 8'hC0;
    localparam logic [7:0] SBQR_FLAG_BLANK = 8'hAA;
    localparam logic [7:0] SBQR_FLAG_USED = 8'h55;
    localparam logic [7:0] SBQR_ERR_CMD = 8'hA1;
    localparam logic [7:0] SBQR_ERR_COMM = 8'hA3;
    localparam logic [7:0] SBQR_ERR_LOCK = 8'h63;
    localparam logic [7:0] SBQR_ID_MARK = 8'h3A;
    localparam logic [7:0] SBQR_ID_COUNT = 8'h13;
    localparam logic [7:0] SBQR_ID_ADDR_LEN = 8'h03;
    localparam logic [7:0] SBQR_ID_RSVD = 8'hFD;
    localparam logic [7:0] SBQR_ROM_SIZE = 8'h80;
    localparam logic [7:0] SBQR_ROM_BLOCKS = 8'h01;
    localparam logic [7:0] SBQR_ROM_START_MID = 8'h80;
    localparam logic [7:0] SBQR_RAM_START_LO = 8'h60;
    localparam logic [7:0] SBQR_RAM_END_LO = 8'h3F;
    localparam logic [7:0] SBQR_BYTE_ZERO = 8'h00;
    localparam logic [7:0] SBQR_BYTE_ONES = 8'hFF;
    localparam logic [7:0] SBQR_RAM_END_MID_DEF = 8'h08;
    localparam logic [4:0] SBQR_ID_PAYLOAD_LEN = 5'h13;
    localparam logic [4:0] SBQR_ID_PAYLOAD_POS = 5'h03;
    localparam logic [4:0] SBQR_ID_LAST = 5'h16;
    localparam logic [4:0] SBQR_SUM_LAST = 5'h02;
    localparam logic [4:0] SBQR_ERR_LAST = 5'h02;
    localparam logic [3:0] SBQR_FRAME_LAST = 4'h9;
    localparam int SBQR_CNT_W = 20;
    localparam int SBQR_MIN_HIGH = 4;

    // Payload of the identification record, counted from the address length byte.
    function automatic logic [7:0] sbqr_id_payload(input logic [4:0] i,
                                                   input logic [7:0] ram_end_mid);
        case (i)
            5'h00: sbqr_id_payload = SBQR_ID_ADDR_LEN; // RL12
            5'h01: sbqr_id_payload = SBQR_ID_RSVD; // RL11
            5'h05: sbqr_id_payload = SBQR_ROM_SIZE; // RL13
            5'h06: sbqr_id_payload = SBQR_ROM_BLOCKS; // RL14
            5'h08: sbqr_id_payload = SBQR_ROM_START_MID; // RL15
            5'h0B, 5'h0C: sbqr_id_payload = SBQR_BYTE_ONES; // RL15
            5'h0F: sbqr_id_payload = SBQR_RAM_START_LO; // RL16
            5'h11: sbqr_id_payload = ram_end_mid; // RL18
            5'h12: sbqr_id_payload = SBQR_RAM_END_LO; // RL16
            default: sbqr_id_payload = SBQR_BYTE_ZERO;
        endcase
    endfunction : sbqr_id_payload

    function automatic logic [7:0] sbqr_id_checksum(input logic [7:0] ram_end_mid);
        logic [7:0] acc;
        acc = 8'h00;
        for (int i = 0; i < int'(SBQR_ID_PAYLOAD_LEN); i++) begin
            acc = acc + sbqr_id_payload(5'(i), ram_end_mid);
        end
        sbqr_id_checksum = 8'h00 - acc; // RL17
    endfunction : sbqr_id_checksum
endpackage : sbqr_pkg

module sbqr_tx import sbqr_pkg::*; #(
    parameter int CNT_W = SBQR_CNT_W
) (
    input wire logic clk_sys, // System clock.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic [CNT_W-1:0] bit_len, // Cycles per bit.
    input wire logic start, // Pulse that loads a byte while idle.
    input wire logic [7:0] data, // Byte to send.
    output logic txd, // Serial line, idle high.
    output logic busy // High while a frame is on the line.
);
    typedef struct packed {
        logic txd;
        logic busy;
        logic [8:0] shf;
        logic [3:0] nbit;
        logic [CNT_W-1:0] div;
    } sbqr_tx_s;

    sbqr_tx_s s_r;
    sbqr_tx_s s_nxt;
    logic tick;

    always_comb begin
        s_nxt = s_r;
        tick = (s_r.div == bit_len - CNT_W'(1));
        if (!s_r.busy) begin
            s_nxt.div = '0;
            if (start) begin
                s_nxt.busy = 1'b1;
                s_nxt.txd = 1'b0;
                s_nxt.shf = {1'b1, data};
                s_nxt.nbit = 4'h0;
            end
        end else if (tick) begin
            s_nxt.div = '0;
            if (s_r.nbit == SBQR_FRAME_LAST) begin
                s_nxt.busy = 1'b0;
            end else begin
                s_nxt.txd = s_r.shf[0];
                s_nxt.shf = {1'b1, s_r.shf[8:1]};
                s_nxt.nbit = s_r.nbit + 4'h1;
            end
        end else begin
            s_nxt.div = s_r.div + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_r <= '{txd: 1'b1, busy: 1'b0, shf: '0, nbit: '0, div: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign txd = s_r.txd;
    assign busy = s_r.busy;

    idle_line_a: assert property (@(posedge clk_sys) disable iff (srst)
        !busy |-> txd) else $error("Line not high while idle.");
endmodule : sbqr_tx

// *** sbqr_responder.sv ***
// Boot link responder: baud lock, matching bytes and the checksum and identity replies.
// Overview of operation
// RL1 - First matching byte sets baud, echoed back.
// RL2 - Second matching byte echoed if valid, else silent.
// RL3 - Bad command sends error code thrice, halts.
// RL4 - Security lock halts until hardware reset.
// RL5 - Communication error sends error code thrice, halts.
// RL6 - Checksum command is not echoed.
// RL7 - Blank flag distinguishes all-erased from programmed.
// RL8 - Checksum high byte then low byte follow.
// RL9 - After a reply, wait for next command.
// RL10 - Identity command echoed, then start mark.
// RL11 - Count byte, reserved byte, three zeros.
// RL12 - First payload byte is address length code.
// RL13 - ROM size code at fixed position.
// RL14 - ROM block count reports one block.
// RL15 - Writable flash start and end addresses.
// RL16 - RAM loader start and end addresses.
// RL17 - Record ends with two's complement checksum.
// RL18 - RAM end middle byte keeps range contiguous.
module sbqr_responder import sbqr_pkg::*; #(
    parameter logic [7:0] RAM_END_MID = SBQR_RAM_END_MID_DEF,
    parameter int CNT_W = SBQR_CNT_W
) (
    input wire logic clk_sys, // System clock, 25 MHz.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic rxd, // Serial line from the controller.
    input wire logic sec_lock, // Flash security enabled.
    input wire logic sum_blank, // Every summed flash byte is erased.
    input wire logic [15:0] sum_val, // Flash checksum.
    output logic txd, // Serial line to the controller.
    output logic link_halted // Link stopped until reset.
);
    typedef enum logic [3:0] {
        ST_AB_IDLE = 4'b0000,
        ST_AB_LOW = 4'b0001,
        ST_AB_HIGH = 4'b0010,
        ST_AB_TAIL = 4'b0011,
        ST_RX_IDLE = 4'b0100,
        ST_RX_START = 4'b0101,
        ST_RX_BITS = 4'b0110,
        ST_RX_STOP = 4'b0111,
        ST_TX_GO = 4'b1000,
        ST_TX_WAIT = 4'b1001,
        ST_HALT = 4'b1010
    } sbqr_state_e;

    typedef enum logic [1:0] {
        RP_ECHO = 2'b00,
        RP_SUM = 2'b01,
        RP_ID = 2'b10,
        RP_ERR = 2'b11
    } sbqr_reply_e;

    typedef struct packed {
        logic rx_s1;
        logic rx_s2;
        logic rx_s3;
        logic rx_lvl;
        sbqr_state_e st;
        sbqr_reply_e rp;
        logic ph_cmd;
        logic halted;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] lo_len;
        logic [CNT_W-1:0] bit_len;
        logic [2:0] bitn;
        logic [7:0] sh;
        logic [7:0] echo;
        logic [4:0] idx;
        logic [4:0] last;
    } sbqr_main_s;

    localparam logic [7:0] ID_CKS = sbqr_id_checksum(RAM_END_MID);

    sbqr_main_s s_r;
    sbqr_main_s s_nxt;
    logic [7:0] tx_byte;
    logic tx_busy;
    logic [CNT_W-1:0] half;
    logic [CNT_W+3:0] hx;
    logic [CNT_W+3:0] lx;
    logic is86;
    logic is30;

    sbqr_tx #(.CNT_W(CNT_W)) u_tx (
        .clk_sys(clk_sys),
        .srst(srst),
        .bit_len(s_r.bit_len),
        .start(s_r.st == ST_TX_GO),
        .data(tx_byte),
        .txd(txd),
        .busy(tx_busy)
    );

    // Byte on offer to the transmitter for the current reply position.
    always_comb begin
        tx_byte = s_r.echo;
        case (s_r.rp)
            RP_SUM: begin
                if (s_r.idx == 5'h00) begin
                    tx_byte = sum_blank ? SBQR_FLAG_BLANK : SBQR_FLAG_USED; // RL7
                end else if (s_r.idx == 5'h01) begin
                    tx_byte = sum_val[15:8]; // RL8
                end else begin
                    tx_byte = sum_val[7:0]; // RL8
                end
            end
            RP_ID: begin
                if (s_r.idx == 5'h00) begin
                    tx_byte = s_r.echo; // RL10
                end else if (s_r.idx == 5'h01) begin
                    tx_byte = SBQR_ID_MARK; // RL10
                end else if (s_r.idx == 5'h02) begin
                    tx_byte = SBQR_ID_COUNT; // RL11
                end else if (s_r.idx == SBQR_ID_LAST) begin
                    tx_byte = ID_CKS; // RL17
                end else begin
                    tx_byte = sbqr_id_payload(s_r.idx - SBQR_ID_PAYLOAD_POS,
                                              RAM_END_MID); // RL12 RL13 RL14 RL15 RL16 RL18
                end
            end
            default: tx_byte = s_r.echo;
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.rx_s1 = rxd;
        s_nxt.rx_s2 = s_r.rx_s1;
        s_nxt.rx_s3 = s_r.rx_s2;
        // A level counts only once two successive samples agree.
        if (s_r.rx_s2 == s_r.rx_s3) begin
            s_nxt.rx_lvl = s_r.rx_s3;
        end
        half = s_r.bit_len >> 1;
        // The high run after the first low run is two bits for either matching byte,
        // so the low run relative to it tells the two bytes apart.
        hx = {4'h0, s_r.cnt};
        lx = {2'b00, s_r.lo_len, 2'b00};
        is86 = (lx >= hx + (hx << 1)) && (lx <= hx + (hx << 2));
        is30 = (lx >= (hx << 3)) && (lx <= (hx << 3) + (hx << 2));
        case (s_r.st)
            ST_AB_IDLE: begin
                s_nxt.cnt = '0;
                if (!s_r.rx_lvl) begin
                    s_nxt.st = ST_AB_LOW;
                end
            end
            ST_AB_LOW: begin
                s_nxt.cnt = s_r.cnt + CNT_W'(1);
                if (s_r.rx_lvl) begin
                    s_nxt.lo_len = s_r.cnt;
                    s_nxt.cnt = '0;
                    s_nxt.st = ST_AB_HIGH;
                end else if (&s_r.cnt) begin
                    s_nxt.st = ST_AB_IDLE;
                end
            end
            ST_AB_HIGH: begin
                s_nxt.cnt = s_r.cnt + CNT_W'(1);
                if (!s_r.rx_lvl) begin
                    s_nxt.cnt = '0;
                    s_nxt.st = ST_AB_IDLE;
                    if ((is86 || is30) && s_r.cnt >= CNT_W'(SBQR_MIN_HIGH)) begin
                        // The run counter ends one short of the true run, so round up.
                        s_nxt.bit_len = (s_r.cnt >> 1) + CNT_W'(s_r.cnt[0]); // RL1
                        s_nxt.echo = is86 ? SBQR_MATCH1_A : SBQR_MATCH1_B; // RL1
                        s_nxt.st = ST_AB_TAIL;
                    end
                end else if (&s_r.cnt) begin
                    s_nxt.st = ST_AB_IDLE;
                end
            end
            ST_AB_TAIL: begin
                // Answer only once the line has sat high for one and a half bit times without a break.
                s_nxt.cnt = s_r.rx_lvl ? s_r.cnt + CNT_W'(1) : '0;
                if (s_r.cnt == s_r.bit_len + half) begin
                    s_nxt.rp = RP_ECHO; // RL1
                    s_nxt.ph_cmd = 1'b0;
                    s_nxt.idx = '0;
                    s_nxt.last = '0;
                    s_nxt.st = ST_TX_GO;
                end
            end
            ST_RX_IDLE: begin
                s_nxt.cnt = '0;
                if (!s_r.rx_lvl) begin
                    s_nxt.st = ST_RX_START;
                end
            end
            ST_RX_START: begin
                s_nxt.cnt = s_r.cnt + CNT_W'(1);
                if (s_r.cnt == half) begin
                    s_nxt.cnt = '0;
                    s_nxt.bitn = '0;
                    s_nxt.st = s_r.rx_lvl ? ST_RX_IDLE : ST_RX_BITS;
                end
            end
            ST_RX_BITS: begin
                s_nxt.cnt = s_r.cnt + CNT_W'(1);
                if (s_r.cnt == s_r.bit_len - CNT_W'(1)) begin
                    s_nxt.cnt = '0;
                    s_nxt.sh = {s_r.rx_lvl, s_r.sh[7:1]};
                    s_nxt.bitn = s_r.bitn + 3'h1;
                    if (s_r.bitn == 3'h7) begin
                        s_nxt.st = ST_RX_STOP;
                    end
                end
            end
            ST_RX_STOP: begin
                s_nxt.cnt = s_r.cnt + CNT_W'(1);
                if (s_r.cnt == s_r.bit_len - CNT_W'(1)) begin
                    s_nxt.cnt = '0;
                    s_nxt.idx = '0;
                    s_nxt.st = ST_TX_GO;
                    s_nxt.rp = RP_ERR;
                    s_nxt.last = SBQR_ERR_LAST;
                    if (!s_r.ph_cmd) begin
                        if (s_r.rx_lvl && (s_r.sh == SBQR_MATCH2_A || s_r.sh == SBQR_MATCH2_B)) begin
                            s_nxt.echo = s_r.sh; // RL2
                            s_nxt.rp = RP_ECHO;
                            s_nxt.last = '0;
                            s_nxt.ph_cmd = 1'b1;
                        end else begin
                            // A bad second byte sends nothing and starts over at baud lock.
                            s_nxt.st = ST_AB_IDLE; // RL2
                        end
                    end else if (!s_r.rx_lvl) begin
                        s_nxt.echo = SBQR_ERR_COMM; // RL5
                    end else if (sec_lock) begin
                        s_nxt.echo = SBQR_ERR_LOCK; // RL4
                    end else if (s_r.sh == SBQR_CMD_SUM) begin
                        s_nxt.rp = RP_SUM; // RL6
                        s_nxt.last = SBQR_SUM_LAST;
                    end else if (s_r.sh == SBQR_CMD_ID) begin
                        s_nxt.echo = s_r.sh; // RL10
                        s_nxt.rp = RP_ID;
                        s_nxt.last = SBQR_ID_LAST;
                    end else begin
                        s_nxt.echo = SBQR_ERR_CMD; // RL3
                    end
                end
            end
            ST_TX_GO: begin
                s_nxt.st = ST_TX_WAIT;
            end
            ST_TX_WAIT: begin
                if (!tx_busy) begin
                    if (s_r.idx != s_r.last) begin
                        s_nxt.idx = s_r.idx + 5'h01;
                        s_nxt.st = ST_TX_GO;
                    end else if (s_r.rp == RP_ERR) begin
                        s_nxt.halted = 1'b1; // RL3
                        s_nxt.st = ST_HALT;
                    end else begin
                        s_nxt.st = ST_RX_IDLE; // RL9
                    end
                end
            end
            ST_HALT: begin
                // Only reset leaves this state, so a locked part stays silent.
                s_nxt.st = ST_HALT; // RL4
            end
            default: s_nxt.st = ST_AB_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_r <= '{rx_s1: 1'b1, rx_s2: 1'b1, rx_s3: 1'b1, rx_lvl: 1'b1, st: ST_AB_IDLE,
                     rp: RP_ECHO, ph_cmd: 1'b0, halted: 1'b0, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link_halted = s_r.halted;

    // Running sum of the identity payload, kept only for checking the closing byte.
    logic [7:0] chk_acc;
    always_ff @(posedge clk_sys) begin
        if (srst || s_r.st != ST_TX_GO || s_r.rp != RP_ID || s_r.idx < SBQR_ID_PAYLOAD_POS) begin
            if (srst || s_r.rp != RP_ID || s_r.idx < SBQR_ID_PAYLOAD_POS) begin
                chk_acc <= 8'h00;
            end
        end else begin
            chk_acc <= chk_acc + tx_byte;
        end
    end

    ab_echo_a: assert property (@(posedge clk_sys) disable iff (srst) // RL1
        (s_r.st == ST_TX_GO && s_r.rp == RP_ECHO && !s_r.ph_cmd) |->
        (tx_byte == SBQR_MATCH1_A || tx_byte == SBQR_MATCH1_B) && s_r.bit_len != '0)
        else $error("First echo is not a matching byte.");
    m2_echo_a: assert property (@(posedge clk_sys) disable iff (srst) // RL2
        (s_r.st == ST_TX_GO && s_r.rp == RP_ECHO && s_r.ph_cmd) |->
        (tx_byte == SBQR_MATCH2_A || tx_byte == SBQR_MATCH2_B))
        else $error("Second echo is not a matching byte.");
    err_code_a: assert property (@(posedge clk_sys) disable iff (srst) // RL3
        (s_r.st == ST_TX_GO && s_r.rp == RP_ERR) |->
        // The first error byte follows some other byte on offer, so only repeats must match.
        (tx_byte == SBQR_ERR_CMD || tx_byte == SBQR_ERR_COMM || tx_byte == SBQR_ERR_LOCK)
        && (s_r.idx == 5'h00 || $stable(tx_byte)))
        else $error("Error reply byte is wrong.");
    halt_entry_a: assert property (@(posedge clk_sys) disable iff (srst) // RL3
        (s_r.st == ST_TX_WAIT && !tx_busy && s_r.rp == RP_ERR && s_r.idx == SBQR_ERR_LAST)
        |=> s_r.st == ST_HALT ##1 s_r.st == ST_HALT && link_halted)
        else $error("No halt after the third error byte.");
    halt_hold_a: assert property (@(posedge clk_sys) disable iff (srst) // RL4
        link_halted |=> link_halted && s_r.st == ST_HALT && !tx_busy)
        else $error("Halted link became active.");
    sum_no_echo_a: assert property (@(posedge clk_sys) disable iff (srst) // RL6
        (s_r.st == ST_RX_STOP && s_nxt.st == ST_TX_GO && s_nxt.rp == RP_SUM) |=>
        s_r.idx == 5'h00 && tx_byte != SBQR_CMD_SUM)
        else $error("Checksum command was echoed.");
    sum_flag_a: assert property (@(posedge clk_sys) disable iff (srst) // RL7
        (s_r.st == ST_TX_GO && s_r.rp == RP_SUM && s_r.idx == 5'h00) |->
        tx_byte == (sum_blank ? SBQR_FLAG_BLANK : SBQR_FLAG_USED))
        else $error("Blank flag wrong.");
    sum_order_a: assert property (@(posedge clk_sys) disable iff (srst) // RL8
        (s_r.st == ST_TX_GO && s_r.rp == RP_SUM && s_r.idx != 5'h00) |->
        tx_byte == ((s_r.idx == 5'h01) ? sum_val[15:8] : sum_val[7:0]))
        else $error("Checksum bytes out of order.");
    reply_end_a: assert property (@(posedge clk_sys) disable iff (srst) // RL9
        (s_r.st == ST_TX_WAIT && !tx_busy && s_r.idx == s_r.last && s_r.rp != RP_ERR)
        |=> s_r.st == ST_RX_IDLE && !link_halted)
        else $error("Reply did not return to command wait.");
    id_mark_a: assert property (@(posedge clk_sys) disable iff (srst) // RL10
        (s_r.st == ST_TX_GO && s_r.rp == RP_ID && s_r.idx <= 5'h01) |->
        tx_byte == ((s_r.idx == 5'h00) ? SBQR_CMD_ID : SBQR_ID_MARK))
        else $error("Identity echo or mark wrong.");
    id_count_a: assert property (@(posedge clk_sys) disable iff (srst) // RL11
        (s_r.st == ST_TX_GO && s_r.rp == RP_ID && s_r.idx == 5'h02) |->
        tx_byte == SBQR_ID_COUNT && s_r.last == SBQR_ID_LAST)
        else $error("Identity count byte wrong.");
    id_cks_a: assert property (@(posedge clk_sys) disable iff (srst) // RL17
        (s_r.st == ST_TX_GO && s_r.rp == RP_ID && s_r.idx == SBQR_ID_LAST) |->
        8'(chk_acc + tx_byte) == 8'h00)
        else $error("Identity checksum wrong.");
endmodule : sbqr_responder

// *** sbqr_ctrl_model.sv ***
// Programming controller model that sends and receives 8N1 bytes on the boot link.
module sbqr_ctrl_model #(
    parameter int BIT = 16
) (
    input wire logic clk_sys, // System clock.
    input wire logic txd, // Serial line from the device.
    output logic rxd // Serial line to the device.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_q[$];
    int frame_errs = 0;

    initial rxd = 1'b1;

    // Bits change on the falling edge; a low stop_ok sends a framing fault on purpose.
    task automatic send_byte(input logic [7:0] b, input logic stop_ok);
        logic [9:0] frame;
        frame = {stop_ok, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_sys);
            rxd <= frame[i];
            repeat (BIT - 1) @(negedge clk_sys);
        end
        @(negedge clk_sys);
        rxd <= 1'b1;
    endtask : send_byte

    // Receiver samples mid-bit at the rate the device should have locked to.
    initial begin
        logic [7:0] b;
        forever begin
            @(negedge clk_sys);
            if (txd === 1'b0) begin
                repeat (BIT / 2) @(negedge clk_sys);
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT) @(negedge clk_sys);
                    b[i] = txd;
                end
                repeat (BIT) @(negedge clk_sys);
                if (txd !== 1'b1) frame_errs++;
                rx_q.push_back(b);
            end
        end
    end
endmodule : sbqr_ctrl_model

// *** serial_boot_query_responder_tb.sv ***
// Self-checking bench for the boot link responder against a controller model.
module serial_boot_query_responder_tb import sbqr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic sec_lock = 1'b0;
    logic sum_blank = 1'b0;
    logic [15:0] sum_val = 16'h0000;
    logic rxd;
    logic txd;
    logic link_halted;
    int err_count = 0;
    int checked = 0;
    int seed = 32'h7A6E;
    logic [7:0] exp_q[$];
    logic [7:0] id_bytes[19] = '{8'h03, 8'hFD, 8'h00, 8'h00, 8'h00, 8'h80, 8'h01, 8'h00,
        8'h80, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h60, 8'h00,
        SBQR_RAM_END_MID_DEF, 8'h3F};
    logic [7:0] err_codes[3] = '{8'hA1, 8'hA3, 8'h63};

    initial forever #20 clk_sys = ~clk_sys;

    sbqr_responder uut (.clk_sys(clk_sys), .srst(srst), .rxd(rxd), .sec_lock(sec_lock),
        .sum_blank(sum_blank), .sum_val(sum_val), .txd(txd), .link_halted(link_halted));
    sbqr_ctrl_model #(.BIT(16)) ctrl (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // The quiet span after the last byte catches any extra or unwanted reply.
    task automatic expect_reply(input string what);
        int n;
        n = 0;
        while (ctrl.rx_q.size() < exp_q.size() && n < 6000) begin
            @(negedge clk_sys);
            n++;
        end
        repeat (400) @(negedge clk_sys);
        check({what, " count"}, 8'(exp_q.size()), 8'(ctrl.rx_q.size()));
        foreach (exp_q[i]) begin
            if (i < ctrl.rx_q.size()) check(what, exp_q[i], ctrl.rx_q[i]);
        end
        ctrl.rx_q.delete();
        exp_q.delete();
    endtask : expect_reply

    task automatic do_reset();
        @(negedge clk_sys);
        srst <= 1'b1;
        repeat (3) @(negedge clk_sys);
        srst <= 1'b0;
        repeat (8) @(negedge clk_sys);
        ctrl.rx_q.delete();
    endtask : do_reset

    task automatic link(input logic [7:0] m1, input logic [7:0] m2);
        ctrl.send_byte(m1, 1'b1);
        exp_q.push_back(m1);
        expect_reply("match one");
        ctrl.send_byte(m2, 1'b1);
        if (m2 == SBQR_MATCH2_A || m2 == SBQR_MATCH2_B) exp_q.push_back(m2);
        expect_reply("match two");
    endtask : link

    initial begin
        logic [7:0] cs;
        logic [7:0] cmd;
        do_reset();
        check("halt after reset", 8'h00, {7'h00, link_halted});
        link(SBQR_MATCH1_A, SBQR_MATCH2_A);
        for (int k = 0; k < 2; k++) begin
            @(negedge clk_sys);
            sum_val <= 16'($random(seed));
            sum_blank <= (k == 0);
            ctrl.send_byte(SBQR_CMD_SUM, 1'b1);
            exp_q.push_back(k == 0 ? 8'hAA : 8'h55);
            exp_q.push_back(sum_val[15:8]);
            exp_q.push_back(sum_val[7:0]);
            expect_reply("sum reply");
        end
        ctrl.send_byte(SBQR_CMD_ID, 1'b1);
        exp_q = '{8'hC0, 8'h3A, 8'h13};
        cs = 8'h00;
        foreach (id_bytes[i]) begin
            exp_q.push_back(id_bytes[i]);
            cs = cs - id_bytes[i];
        end
        exp_q.push_back(cs);
        expect_reply("id reply");
        // Case 0 follows the identity reply directly, so the device must be back at command wait.
        for (int k = 0; k < 3; k++) begin
            if (k > 0) do_reset();
            if (k == 1) link(SBQR_MATCH1_B, 8'h55);
            if (k == 1) link(SBQR_MATCH1_B, SBQR_MATCH2_B);
            if (k == 2) link(SBQR_MATCH1_A, SBQR_MATCH2_B);
            cmd = 8'($random(seed));
            if (cmd == SBQR_CMD_SUM || cmd == SBQR_CMD_ID || k > 0) cmd = SBQR_CMD_SUM;
            @(negedge clk_sys);
            sec_lock <= (k == 2);
            ctrl.send_byte(cmd, k != 1);
            repeat (3) exp_q.push_back(err_codes[k]);
            expect_reply("error reply");
            check("halted", 8'h01, {7'h00, link_halted});
            sec_lock <= 1'b0;
            ctrl.send_byte(SBQR_MATCH1_A, 1'b1);
            ctrl.send_byte(SBQR_CMD_SUM, 1'b1);
            expect_reply("after halt");
            check("still halted", 8'h01, {7'h00, link_halted});
        end
        check("stop bits", 8'h00, 8'(ctrl.frame_errs));
        summarize();
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        err_count++;
        summarize();
    end
endmodule : serial_boot_query_responder_tb
